// ===== core/srd_pkg.sv
// Functional notes
// - Register chosen by instruction number field; time base reads also need the time base flag.
// - Number 947 is core configuration, read/write.
// - Instruction compares at 1012, 1013, 948, 949.
// - Data compares 1014/1015, value compares 950/951.
// - Debug control zero 1010, one 957.
// - Writes to 1008 and 984 clear bits.
// - Timer status readable at 984.
// - Timer control 986, interval timer 987.
// - Cache attribute registers 1018, 954, 1019.
// - Number 979 icache debug data, read only.
// - Number 287 processor version, read only.
// - Syndrome 980, error address 981, vector 982.
// - Save/restore registers at 26, 27, 990, 991.
// - Scratch zero to three at 272-275.
// - Scratch four-seven written 276-279, read 260-263.
// - User scratch zero at 256.
// - Time base written 284/285, read 268/269 only.
// - Storage attribute, zone and process registers decoded.
// - Loop count 9, return link 8, exception 1.
package srd_pkg;

   // ==========================================
   // Widths and basic types
   localparam int unsigned WORD_W = 32;
   localparam int unsigned NUM_W = 10;
   localparam int unsigned SLOT_COUNT = 44;
   typedef logic [WORD_W-1:0] srd_word_t;
   typedef logic [NUM_W-1:0] srd_num_t;
   typedef logic [5:0] srd_slot_t;

   // ==========================================
   // Word constants
   localparam srd_word_t WORD_ZERO = 32'h0000_0000;
   localparam srd_word_t WORD_ONES = 32'hffff_ffff;
   localparam srd_word_t TB_STEP = 32'h0000_0001;
   // Arbitrary version code, names no real part
   localparam srd_word_t VERSION_DEFAULT = 32'h0001_0000;

   // ==========================================
   // Special register numbers
   localparam srd_num_t N_FIXED_POINT_EXCEPTION = 10'h001;
   localparam srd_num_t N_RETURN_LINK = 10'h008;
   localparam srd_num_t N_LOOP_COUNT = 10'h009;
   localparam srd_num_t N_SAVE_RESTORE_0 = 10'h01a;
   localparam srd_num_t N_SAVE_RESTORE_1 = 10'h01b;
   localparam srd_num_t N_USER_SCRATCH_0 = 10'h100;
   localparam srd_num_t N_SCRATCH_4_READ = 10'h104;
   localparam srd_num_t N_TB_LOWER_READ = 10'h10c;
   localparam srd_num_t N_TB_UPPER_READ = 10'h10d;
   localparam srd_num_t N_SCRATCH_0 = 10'h110;
   localparam srd_num_t N_SCRATCH_1 = 10'h111;
   localparam srd_num_t N_SCRATCH_2 = 10'h112;
   localparam srd_num_t N_SCRATCH_3 = 10'h113;
   localparam srd_num_t N_SCRATCH_4_WRITE = 10'h114;
   localparam srd_num_t N_SCRATCH_5_WRITE = 10'h115;
   localparam srd_num_t N_SCRATCH_6_WRITE = 10'h116;
   localparam srd_num_t N_SCRATCH_7_WRITE = 10'h117;
   localparam srd_num_t N_TIME_BASE_LOWER = 10'h11c;
   localparam srd_num_t N_TIME_BASE_UPPER = 10'h11d;
   localparam srd_num_t N_PROCESSOR_VERSION = 10'h11f;
   localparam srd_num_t N_ZONE_PROTECTION = 10'h3b0;
   localparam srd_num_t N_PROCESS_TAG = 10'h3b1;
   localparam srd_num_t N_CORE_CONFIGURATION = 10'h3b3;
   localparam srd_num_t N_INSTR_ADDR_COMPARE_3 = 10'h3b4;
   localparam srd_num_t N_INSTR_ADDR_COMPARE_4 = 10'h3b5;
   localparam srd_num_t N_DATA_VALUE_COMPARE_1 = 10'h3b6;
   localparam srd_num_t N_DATA_VALUE_COMPARE_2 = 10'h3b7;
   localparam srd_num_t N_STORAGE_GUARDED = 10'h3b9;
   localparam srd_num_t N_DCACHE_WRITE_THROUGH = 10'h3ba;
   localparam srd_num_t N_STORAGE_LITTLE_ENDIAN = 10'h3bb;
   localparam srd_num_t N_STORAGE_USER_DEFINED_0 = 10'h3bc;
   localparam srd_num_t N_DEBUG_CONTROL_1 = 10'h3bd;
   localparam srd_num_t N_ICACHE_DEBUG_DATA = 10'h3d3;
   localparam srd_num_t N_EXCEPTION_SYNDROME = 10'h3d4;
   localparam srd_num_t N_DATA_ERROR_ADDRESS = 10'h3d5;
   localparam srd_num_t N_EXCEPTION_VECTOR_PREFIX = 10'h3d6;
   localparam srd_num_t N_TIMER_STATUS = 10'h3d8;
   localparam srd_num_t N_TIMER_CONTROL = 10'h3da;
   localparam srd_num_t N_INTERVAL_TIMER = 10'h3db;
   localparam srd_num_t N_SAVE_RESTORE_2 = 10'h3de;
   localparam srd_num_t N_SAVE_RESTORE_3 = 10'h3df;
   localparam srd_num_t N_DEBUG_STATUS = 10'h3f0;
   localparam srd_num_t N_DEBUG_CONTROL_0 = 10'h3f2;
   localparam srd_num_t N_INSTR_ADDR_COMPARE_1 = 10'h3f4;
   localparam srd_num_t N_INSTR_ADDR_COMPARE_2 = 10'h3f5;
   localparam srd_num_t N_DATA_ADDR_COMPARE_1 = 10'h3f6;
   localparam srd_num_t N_DATA_ADDR_COMPARE_2 = 10'h3f7;
   localparam srd_num_t N_DCACHE_CACHABILITY = 10'h3fa;
   localparam srd_num_t N_ICACHE_CACHABILITY = 10'h3fb;

   // ==========================================
   // Storage slots, by write number
   localparam srd_num_t SLOT_NUMBER [SLOT_COUNT] = '{
      N_FIXED_POINT_EXCEPTION, N_RETURN_LINK, N_LOOP_COUNT,
      N_SAVE_RESTORE_0, N_SAVE_RESTORE_1, N_SAVE_RESTORE_2, N_SAVE_RESTORE_3,
      N_USER_SCRATCH_0, N_SCRATCH_0, N_SCRATCH_1, N_SCRATCH_2, N_SCRATCH_3,
      N_SCRATCH_4_WRITE, N_SCRATCH_5_WRITE, N_SCRATCH_6_WRITE, N_SCRATCH_7_WRITE,
      N_TIME_BASE_LOWER, N_TIME_BASE_UPPER, N_ZONE_PROTECTION, N_PROCESS_TAG,
      N_CORE_CONFIGURATION, N_INSTR_ADDR_COMPARE_1, N_INSTR_ADDR_COMPARE_2,
      N_INSTR_ADDR_COMPARE_3, N_INSTR_ADDR_COMPARE_4, N_DATA_VALUE_COMPARE_1,
      N_DATA_VALUE_COMPARE_2, N_STORAGE_GUARDED, N_DCACHE_WRITE_THROUGH,
      N_STORAGE_LITTLE_ENDIAN, N_STORAGE_USER_DEFINED_0, N_DEBUG_CONTROL_0,
      N_DEBUG_CONTROL_1, N_EXCEPTION_SYNDROME, N_DATA_ERROR_ADDRESS,
      N_EXCEPTION_VECTOR_PREFIX, N_TIMER_STATUS, N_TIMER_CONTROL,
      N_INTERVAL_TIMER, N_DEBUG_STATUS, N_DATA_ADDR_COMPARE_1,
      N_DATA_ADDR_COMPARE_2, N_DCACHE_CACHABILITY, N_ICACHE_CACHABILITY};
   localparam srd_slot_t SLOT_SCRATCH_4 = 6'h0c;
   localparam srd_slot_t SLOT_SCRATCH_7 = 6'h0f;
   localparam srd_slot_t SLOT_TB_LOWER = 6'h10;
   localparam srd_slot_t SLOT_TB_UPPER = 6'h11;
   localparam srd_slot_t SLOT_TIMER_STATUS = 6'h24;
   localparam srd_slot_t SLOT_DEBUG_STATUS = 6'h27;
   localparam srd_slot_t SLOT_NONE = 6'h00;
   localparam srd_num_t SCRATCH_READ_SPAN = 10'h003;

   // ==========================================
   // Read source selection
   typedef enum logic [1:0] {
      SRC_SLOT = 2'b00,
      SRC_VERSION = 2'b01,
      SRC_ICACHE = 2'b10,
      SRC_NONE = 2'b11
   } srd_src_e;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic write;
      logic time_base_read;
      srd_num_t special_register_number;
      srd_word_t data;
   } srd_req_s;

   typedef struct packed {
      logic valid;
      logic invalid;
      srd_word_t data;
   } srd_rsp_s;

   typedef struct packed {
      srd_src_e src;
      srd_slot_t slot;
   } srd_sel_s;

endpackage

// ===== core/srd_special_register_decode.sv
`timescale 1ns/1ps
module srd_special_register_decode #(
   parameter srd_pkg::srd_word_t VERSION_VALUE = srd_pkg::VERSION_DEFAULT
) (
   input wire logic clk,
   input wire logic nrst,
   input wire srd_pkg::srd_req_s req,
   input wire srd_pkg::srd_word_t icache_debug_word,
   input wire srd_pkg::srd_word_t timer_status_set,
   input wire srd_pkg::srd_word_t debug_status_set,
   output srd_pkg::srd_rsp_s rsp
);
   import srd_pkg::*;

   // ==========================================
   // Decode helpers
   // Search the slot table for a write number
   function automatic srd_sel_s find_slot(input srd_num_t num);
      srd_sel_s sel;
      sel.src = SRC_NONE;
      sel.slot = SLOT_NONE;
      for (int i = 0; i < SLOT_COUNT; i++) begin
         if (SLOT_NUMBER[i] == num) begin
            sel.src = SRC_SLOT;
            sel.slot = srd_slot_t'(i);
         end
      end
      return sel;
   endfunction

   // True for slots with no ordinary read number
   function automatic logic write_only_slot(input srd_slot_t s);
      return (s >= SLOT_SCRATCH_4 && s <= SLOT_SCRATCH_7) ||
             s == SLOT_TB_LOWER || s == SLOT_TB_UPPER;
   endfunction

   // True for the two clear-on-write status slots
   function automatic logic status_slot(input srd_slot_t s);
      return s == SLOT_TIMER_STATUS || s == SLOT_DEBUG_STATUS;
   endfunction

   // ==========================================
   // Storage and decode signals
   srd_word_t regs_reg [SLOT_COUNT]; // Backing words, one per slot
   srd_sel_s wsel; // Write target
   srd_sel_s rsel; // Read source
   srd_num_t num; // Incoming register number
   srd_num_t scratch_off; // Offset into split scratch reads
   logic write_ok; // Legal write move
   logic read_ok; // Legal read move
   srd_word_t read_word; // Selected read data
   srd_word_t tb_lower_next; // Counting lower half
   logic tb_carry; // Lower half wraps this cycle
   srd_rsp_s rsp_next; // Next answer

   assign num = req.special_register_number;
   assign scratch_off = num - N_SCRATCH_4_READ;

   // ==========================================
   // Number decode
   // Write side: slot table only, read-only numbers absent
   always_comb begin
      wsel = find_slot(num);
   end

   // Read side: split numbers, read-only sources, time base
   always_comb begin
      rsel.src = SRC_NONE;
      rsel.slot = SLOT_NONE;
      if (req.time_base_read) begin
         // Time base halves come back only here
         if (num == N_TB_LOWER_READ) begin
            rsel.src = SRC_SLOT;
            rsel.slot = SLOT_TB_LOWER;
         end else if (num == N_TB_UPPER_READ) begin
            rsel.src = SRC_SLOT;
            rsel.slot = SLOT_TB_UPPER;
         end
      end else if (num >= N_SCRATCH_4_READ &&
                   num <= N_SCRATCH_4_READ + SCRATCH_READ_SPAN) begin
         // Scratch four to seven read sixteen below their write numbers
         rsel.src = SRC_SLOT;
         rsel.slot = SLOT_SCRATCH_4 + srd_slot_t'(scratch_off);
      end else if (num == N_PROCESSOR_VERSION) begin
         rsel.src = SRC_VERSION;
      end else if (num == N_ICACHE_DEBUG_DATA) begin
         rsel.src = SRC_ICACHE;
      end else begin
         // Ordinary numbers, excluding write-only ones
         rsel = find_slot(num);
         if (rsel.src == SRC_SLOT && write_only_slot(rsel.slot)) begin
            rsel.src = SRC_NONE;
            rsel.slot = SLOT_NONE;
         end
      end
   end

   // ==========================================
   // Legality
   // Unknown numbers and read-only writes change nothing
   always_comb begin
      write_ok = req.valid && req.write && !req.time_base_read &&
                 wsel.src == SRC_SLOT;
      read_ok = req.valid && !req.write && rsel.src != SRC_NONE;
   end

   // ==========================================
   // Read mux
   // Full words from the selected source
   always_comb begin
      case (rsel.src)
         SRC_SLOT: begin
            read_word = regs_reg[rsel.slot];
         end
         SRC_VERSION: begin
            read_word = VERSION_VALUE;
         end
         SRC_ICACHE: begin
            read_word = icache_debug_word;
         end
         default: begin
            read_word = WORD_ZERO;
         end
      endcase
   end

   // ==========================================
   // Time base counting
   always_comb begin
      tb_lower_next = regs_reg[SLOT_TB_LOWER] + TB_STEP;
      tb_carry = regs_reg[SLOT_TB_LOWER] == WORD_ONES;
   end

   // ==========================================
   // Register storage
   // Plain slots store the full move word; specials follow
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            regs_reg[i] <= WORD_ZERO;
         end
      end else begin
         // Ordinary read/write slots
         for (int i = 0; i < SLOT_COUNT; i++) begin
            if (write_ok && wsel.slot == srd_slot_t'(i)) begin
               regs_reg[i] <= req.data;
            end
         end
         // Status slots: write clears bits, hardware set wins
         for (int i = 0; i < SLOT_COUNT; i++) begin
            if (status_slot(srd_slot_t'(i))) begin
               if (write_ok && wsel.slot == srd_slot_t'(i)) begin
                  regs_reg[i] <= (regs_reg[i] & ~req.data) |
                     (srd_slot_t'(i) == SLOT_TIMER_STATUS ?
                      timer_status_set : debug_status_set);
               end else begin
                  regs_reg[i] <= regs_reg[i] |
                     (srd_slot_t'(i) == SLOT_TIMER_STATUS ?
                      timer_status_set : debug_status_set);
               end
            end
         end
         // Time base: counts every cycle, writes load a half
         if (write_ok && wsel.slot == SLOT_TB_LOWER) begin
            regs_reg[SLOT_TB_LOWER] <= req.data;
         end else begin
            regs_reg[SLOT_TB_LOWER] <= tb_lower_next;
         end
         if (write_ok && wsel.slot == SLOT_TB_UPPER) begin
            regs_reg[SLOT_TB_UPPER] <= req.data;
         end else if (tb_carry) begin
            regs_reg[SLOT_TB_UPPER] <= regs_reg[SLOT_TB_UPPER] + TB_STEP;
         end
      end
   end

   // ==========================================
   // Answer to the pipeline
   always_comb begin
      rsp_next.valid = req.valid;
      rsp_next.invalid = req.valid && !(write_ok || read_ok);
      rsp_next.data = read_ok ? read_word : WORD_ZERO;
   end

   // Registered answer, one cycle after the request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rsp <= '0;
      end else begin
         rsp <= rsp_next;
      end
   end

endmodule

// ===== tb/srd_pipe_model.sv
`timescale 1ns/1ps
// ==========================================
// Execution pipeline issuing register moves
module srd_pipe_model (
   input wire logic clk,
   input wire srd_pkg::srd_rsp_s rsp,
   output srd_pkg::srd_req_s req
);
   import srd_pkg::*;
   srd_rsp_s got [$]; // Answers in arrival order

   initial req = '0;

   // One move per edge, held until the taking edge
   task automatic move(input logic w, input logic t, input srd_num_t n, input srd_word_t d);
      req <= '{valid: 1'b1, write: w, time_base_read: t, special_register_number: n, data: d};
      @(posedge clk);
   endtask

   // Empty slot in the move stream
   task automatic idle();
      req <= '0;
      @(posedge clk);
   endtask

   // Collect answers once settled
   always @(negedge clk) begin
      if (rsp.valid === 1'b1) begin
         got.push_back(rsp);
      end
   end
endmodule

// ===== tb/srd_special_register_decode_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checks of the register move decoder
module srd_special_register_decode_chk #(
   parameter srd_pkg::srd_word_t VERSION_VALUE = srd_pkg::VERSION_DEFAULT
) (
   input wire logic clk,
   input wire logic nrst,
   input wire srd_pkg::srd_req_s req,
   input wire srd_pkg::srd_word_t icache_debug_word,
   input wire srd_pkg::srd_word_t timer_status_set,
   input wire srd_pkg::srd_word_t debug_status_set,
   input wire srd_pkg::srd_rsp_s rsp
);
   import srd_pkg::*;
   // Plain read, plain write and the number field
   wire logic rd = req.valid && !req.write && !req.time_base_read;
   wire logic wr = req.valid && req.write && !req.time_base_read;
   wire srd_num_t num = req.special_register_number;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_answer_follows: assert property (req.valid |=> rsp.valid)
      else $error("No answer after a move");
   a_no_stray: assert property (!req.valid |=> !rsp.valid)
      else $error("Answer without a move");
   a_write_zero: assert property (req.valid && req.write |=> rsp.data == WORD_ZERO)
      else $error("Write answer carries data");
   a_unknown_bad: assert property (req.valid && num == 10'h3ff |=> rsp.invalid)
      else $error("Unknown number accepted");
   a_version_ro: assert property (wr && num == N_PROCESSOR_VERSION |=> rsp.invalid)
      else $error("Version write accepted");
   a_version_read: assert property (rd && num == N_PROCESSOR_VERSION
      |=> !rsp.invalid && rsp.data == VERSION_VALUE) else $error("Version read wrong");
   a_icache_read: assert property (rd && num == N_ICACHE_DEBUG_DATA
      |=> rsp.data == $past(icache_debug_word)) else $error("Icache debug read wrong");
   a_config_back: assert property ((wr && num == N_CORE_CONFIGURATION) ##1
      (rd && num == N_CORE_CONFIGURATION) |=> rsp.data == $past(req.data, 2))
      else $error("Configuration read back wrong");
   a_scratch_split: assert property ((wr && num == N_SCRATCH_4_WRITE) ##1
      (rd && num == N_SCRATCH_4_READ) |=> rsp.data == $past(req.data, 2))
      else $error("Scratch read back wrong");
   a_tb_flag: assert property (rd && num == N_TIME_BASE_LOWER |=> rsp.invalid)
      else $error("Time base read without flag");
endmodule

bind srd_special_register_decode srd_special_register_decode_chk #(
   .VERSION_VALUE(VERSION_VALUE)
) u_chk (
   .clk(clk), .nrst(nrst), .req(req), .icache_debug_word(icache_debug_word),
   .timer_status_set(timer_status_set), .debug_status_set(debug_status_set), .rsp(rsp)
);

// ===== tb/test_special_register_access_decode.sv
`timescale 1ns/1ps
module test_special_register_access_decode;
   import srd_pkg::*;
   // ==========================================
   // Signals and bookkeeping
   logic clk = 1'b0;
   logic nrst = 1'b0;
   srd_word_t icache_debug_word = WORD_ZERO;
   srd_word_t timer_status_set = WORD_ZERO;
   srd_word_t debug_status_set = WORD_ZERO;
   srd_req_s req;
   srd_rsp_s rsp;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int seed = 81;
   srd_word_t shadow [SLOT_COUNT]; // Expected contents per slot
   srd_rsp_s eq [$]; // Expected answers of the running test
   // Refused moves: write, time-base flag, number
   localparam logic [11:0] BAD [10] = '{{1'b1, 1'b0, N_PROCESSOR_VERSION},
      {1'b1, 1'b0, N_ICACHE_DEBUG_DATA}, {1'b1, 1'b0, N_SCRATCH_4_READ},
      {1'b1, 1'b0, N_TB_LOWER_READ}, {1'b0, 1'b0, N_SCRATCH_4_WRITE},
      {1'b0, 1'b0, N_TIME_BASE_LOWER}, {1'b1, 1'b1, N_TB_LOWER_READ},
      {1'b0, 1'b1, N_CORE_CONFIGURATION}, {1'b0, 1'b0, 10'h3ff}, {1'b1, 1'b0, 10'h000}};

   always #50 clk = ~clk;

   srd_special_register_decode dut (.clk(clk), .nrst(nrst), .req(req),
      .icache_debug_word(icache_debug_word), .timer_status_set(timer_status_set),
      .debug_status_set(debug_status_set), .rsp(rsp));
   srd_pipe_model pipe (.clk(clk), .rsp(rsp), .req(req));

   // ==========================================
   // Expectation helpers
   function automatic srd_rsp_s ans(input logic inv, input srd_word_t d);
      return '{valid: 1'b1, invalid: inv, data: d};
   endfunction
   // Slots holding plain stored words
   function automatic logic plain(input int k);
      return !(k inside {SLOT_TB_LOWER, SLOT_TB_UPPER, SLOT_TIMER_STATUS, SLOT_DEBUG_STATUS});
   endfunction
   // Scratch four to seven read sixteen numbers lower
   function automatic srd_num_t rd_num(input int k);
      return (k >= SLOT_SCRATCH_4 && k <= SLOT_SCRATCH_7) ?
         SLOT_NUMBER[k] - 10'h010 : SLOT_NUMBER[k];
   endfunction

   // ==========================================
   // Tasks
   task automatic chk(input srd_rsp_s seen, input srd_rsp_s exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: answer %h expected %h", $time, seen, exp);
      end
   endtask
   // Issue a move and note its answer
   task automatic mv(input logic w, input logic t, input srd_num_t n, input srd_word_t d,
                     input srd_rsp_s e);
      pipe.move(w, t, n, d);
      eq.push_back(e);
   endtask
   task automatic wr(input int k, input srd_word_t d);
      mv(1'b1, 1'b0, SLOT_NUMBER[k], d, ans(1'b0, WORD_ZERO));
      shadow[k] = d;
   endtask
   task automatic rd(input int k);
      mv(1'b0, 1'b0, rd_num(k), WORD_ZERO, ans(1'b0, shadow[k]));
   endtask
   // Drain answers, compare all, start afresh
   task automatic end_test(input string name);
      int n;
      pipe.idle();
      pipe.idle();
      n = (pipe.got.size() > eq.size()) ? pipe.got.size() : eq.size();
      for (int i = 0; i < n; i++) begin
         chk(pipe.got[i], eq[i]);
      end
      $display("Test %s finished with %0d answers", name, n);
      pipe.got.delete();
      eq.delete();
   endtask
   task automatic do_reset();
      nrst <= 1'b0;
      foreach (shadow[i]) shadow[i] = WORD_ZERO;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         $display("ERROR %0t: run timed out", $time);
         complete_run();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      int k;
      srd_word_t d;
      srd_word_t m;
      do_reset();
      // Reset value, write, read back at once for every plain slot
      for (int s = 0; s < SLOT_COUNT; s++) begin
         if (plain(s)) begin
            rd(s);
            wr(s, (s % 3 == 0) ? WORD_ONES : $random(seed));
            rd(s);
         end
      end
      end_test("sweep");
      // Random back to back traffic
      repeat (300) begin
         k = {$random(seed)} % SLOT_COUNT;
         if (plain(k)) begin
            if ($random(seed) & 1) wr(k, $random(seed));
            else rd(k);
         end
      end
      end_test("random");
      // Refused moves leave state alone
      icache_debug_word <= $random(seed);
      foreach (BAD[i]) mv(BAD[i][11], BAD[i][10], BAD[i][9:0], WORD_ONES, ans(1'b1, WORD_ZERO));
      rd(SLOT_SCRATCH_4);
      mv(1'b0, 1'b0, N_PROCESSOR_VERSION, WORD_ZERO, ans(1'b0, VERSION_DEFAULT));
      mv(1'b0, 1'b0, N_ICACHE_DEBUG_DATA, WORD_ZERO, ans(1'b0, icache_debug_word));
      end_test("refused");
      // Time base halves, lower wrapping into upper
      d = $random(seed);
      mv(1'b1, 1'b0, N_TIME_BASE_UPPER, d, ans(1'b0, WORD_ZERO));
      mv(1'b1, 1'b0, N_TIME_BASE_LOWER, WORD_ONES, ans(1'b0, WORD_ZERO));
      pipe.idle();
      mv(1'b0, 1'b1, N_TB_UPPER_READ, WORD_ZERO, ans(1'b0, d + TB_STEP));
      mv(1'b0, 1'b1, N_TB_LOWER_READ, WORD_ZERO, ans(1'b0, TB_STEP));
      end_test("time_base");
      // Status bits set by hardware, cleared by writes
      for (int j = 0; j < 2; j++) begin
         d = $random(seed);
         m = $random(seed);
         if (j == 0) timer_status_set <= d;
         else debug_status_set <= d;
         // Empty slot, so the hardware set is stored before the status read
         pipe.idle();
         timer_status_set <= WORD_ZERO;
         debug_status_set <= WORD_ZERO;
         k = j ? SLOT_DEBUG_STATUS : SLOT_TIMER_STATUS;
         mv(1'b0, 1'b0, SLOT_NUMBER[k], WORD_ZERO, ans(1'b0, d));
         mv(1'b1, 1'b0, SLOT_NUMBER[k], m, ans(1'b0, WORD_ZERO));
         mv(1'b0, 1'b0, SLOT_NUMBER[k], WORD_ZERO, ans(1'b0, d & ~m));
         // Set and clear of the same bits in one cycle: set wins
         if (j == 0) timer_status_set <= m;
         else debug_status_set <= m;
         mv(1'b1, 1'b0, SLOT_NUMBER[k], m, ans(1'b0, WORD_ZERO));
         timer_status_set <= WORD_ZERO;
         debug_status_set <= WORD_ZERO;
         mv(1'b0, 1'b0, SLOT_NUMBER[k], WORD_ZERO, ans(1'b0, d | m));
      end
      end_test("clear");
      // Second reset in mid run empties the store
      do_reset();
      rd(0);
      rd(SLOT_SCRATCH_4);
      end_test("reset");
      complete_run();
   end
endmodule
